/* File: hdl/ack_timer_unit.sv */
`timescale 1ns/1ps
module ack_timer_unit
    import lapd_xmit_pkg::*;
#(
    parameter int UNIT_CYCLES = ACK_UNIT_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic [7:0] i_period,
    output logic o_expired,
    output logic o_running
);
    localparam int PRE_W = (UNIT_CYCLES > 1) ? $clog2(UNIT_CYCLES) : 1;

    // Refuse a unit length that the prescaler cannot count.
    if (UNIT_CYCLES < 1) begin : g_bad_unit
        $error("ack_timer_unit: UNIT_CYCLES must be at least 1");
    end

    logic [PRE_W-1:0] pre_reg;
    logic [7:0] units_reg;
    logic running_reg;
    logic expired_reg;

    // Stop wins over start so that a timer write always leaves it idle.
    always_ff @(posedge i_clock) begin
        expired_reg <= 1'b0;
        if (i_rst || i_stop) begin
            running_reg <= 1'b0;
            pre_reg <= '0;
            units_reg <= 8'h00;
        end else if (i_start) begin
            running_reg <= 1'b1;
            pre_reg <= '0;
            units_reg <= (i_period == 8'h00) ? 8'h01 : i_period; // A zero period counts as one.
        end else if (running_reg) begin
            if (pre_reg == PRE_W'(UNIT_CYCLES - 1)) begin
                pre_reg <= '0;
                if (units_reg == 8'h01) begin
                    running_reg <= 1'b0;
                    expired_reg <= 1'b1;
                end else begin
                    units_reg <= units_reg - 8'h01;
                end
            end else begin
                pre_reg <= pre_reg + PRE_W'(1);
            end
        end
    end

    assign o_expired = expired_reg;
    assign o_running = running_reg;

endmodule // ack_timer_unit

/* File: hdl/lapd_xmit_ctrl.sv */
`timescale 1ns/1ps
module lapd_xmit_ctrl
    import lapd_xmit_pkg::*;
#(
    parameter int UNIT_CYCLES = ACK_UNIT_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire axi_req_s i_axi,
    output axi_rsp_s o_axi,
    input wire link_in_s i_link,
    output link_out_s o_link,
    output logic o_transmit_pool_ready_irq,
    output logic o_message_repeat_irq,
    output logic o_timer_expiry_irq,
    output logic o_waiting_for_ack_flag,
    output logic o_timer_recovery_flag
);
    // Decoding shared by the read and the write path.
    function automatic logic [2:0] reg_index(input logic [7:0] addr);
        case (addr)
            OFS_MODE: reg_index = SEL_MODE;
            OFS_CMD: reg_index = SEL_CMD;
            OFS_TIMER: reg_index = SEL_TIMER;
            OFS_STATUS: reg_index = SEL_STATUS;
            OFS_EVENT: reg_index = SEL_EVENT;
            default: reg_index = SEL_NONE;
        endcase
    endfunction

    logic aw_free_reg;
    logic w_free_reg;
    logic ar_free_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [1:0] mode_reg;
    logic [7:0] period_reg;
    logic [3:0] retry_limit_reg;
    logic [2:0] event_reg;
    xmit_state_e state_reg;
    logic is_iframe_reg;
    logic wfa_reg;
    logic timer_recovery_flag_reg;
    logic [3:0] rc_reg;
    link_out_s link_reg;
    logic xpr_reg;
    logic xmr_reg;
    logic tin_reg;
    logic timer_start_reg;
    logic timer_expired;
    logic timer_running;
    logic do_write;
    logic [2:0] wr_sel;
    logic wr_mode;
    logic wr_cmd;
    logic wr_timer;
    logic wr_event;
    logic cmd_xif;
    logic cmd_xtf;
    logic cmd_transmitter_reset_cmd;
    logic cmd_rhr;
    logic auto_mode;
    logic [31:0] rd_word;
    logic rd_ok;

    // A write is performed once address and data are both held and no response waits.
    assign do_write = !aw_free_reg && !w_free_reg && !bvalid_reg;
    assign wr_sel = reg_index(aw_addr_reg);
    assign wr_mode = do_write && wr_sel == SEL_MODE && w_strb_reg[0];
    assign wr_cmd = do_write && wr_sel == SEL_CMD && w_strb_reg[0];
    assign wr_timer = do_write && wr_sel == SEL_TIMER && (|w_strb_reg[1:0]);
    assign wr_event = do_write && wr_sel == SEL_EVENT && w_strb_reg[0];
    assign cmd_xif = wr_cmd && w_data_reg[CMD_XIF_BIT];
    assign cmd_xtf = wr_cmd && w_data_reg[CMD_XTF_BIT];
    assign cmd_transmitter_reset_cmd = wr_cmd && w_data_reg[CMD_TRANSMITTER_RESET_CMD_BIT];
    assign cmd_rhr = wr_cmd && w_data_reg[CMD_RHR_BIT];
    assign auto_mode = !mode_reg[MODE_NAM_BIT];

    // Write address and data channels are taken independently, in either order.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            aw_free_reg <= 1'b1;
            w_free_reg <= 1'b1;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
        end else begin
            if (aw_free_reg && i_axi.awvalid) begin
                aw_free_reg <= 1'b0;
                aw_addr_reg <= i_axi.awaddr;
            end else if (do_write) begin
                aw_free_reg <= 1'b1;
            end
            if (w_free_reg && i_axi.wvalid) begin
                w_free_reg <= 1'b0;
                w_data_reg <= i_axi.wdata;
                w_strb_reg <= i_axi.wstrb;
            end else if (do_write) begin
                w_free_reg <= 1'b1;
            end
        end
    end

    // Write response; an unmapped address answers SLVERR and changes nothing.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (bvalid_reg && i_axi.bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Software-owned configuration.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            mode_reg <= MODE_RESET;
            period_reg <= PERIOD_RESET;
            retry_limit_reg <= RETRY_RESET;
        end else begin
            if (wr_mode) begin
                mode_reg <= w_data_reg[1:0];
            end
            if (wr_timer && w_strb_reg[0]) begin
                period_reg <= w_data_reg[TMR_PERIOD_LSB +: 8];
            end
            if (wr_timer && w_strb_reg[1]) begin
                retry_limit_reg <= w_data_reg[TMR_RETRY_LSB +: 4];
            end
        end
    end

    // Read data mux; the timer recovery flag and peer busy read zero outside auto mode.
    always_comb begin
        rd_word = 32'h0;
        rd_ok = 1'b1;
        case (reg_index(i_axi.araddr))
            SEL_MODE: rd_word[1:0] = mode_reg;
            SEL_CMD: rd_word = 32'h0;
            SEL_TIMER: rd_word[11:0] = {retry_limit_reg, period_reg};
            SEL_STATUS: begin
                rd_word[ST_WFA_BIT] = wfa_reg;
                rd_word[ST_TIMER_RECOVERY_FLAG_BIT] = timer_recovery_flag_reg && auto_mode;
                rd_word[ST_BUSY_BIT] = i_link.peer_busy && auto_mode;
                rd_word[ST_TXACT_BIT] = state_reg != ST_IDLE;
                rd_word[ST_RC_LSB +: 4] = rc_reg;
            end
            SEL_EVENT: rd_word[2:0] = event_reg;
            default: rd_ok = 1'b0;
        endcase
    end

    // Read channel answers one cycle after the address is taken.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ar_free_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= RESP_OKAY;
        end else if (ar_free_reg && i_axi.arvalid) begin
            ar_free_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg && i_axi.rready) begin
            ar_free_reg <= 1'b1;
            rvalid_reg <= 1'b0;
        end
    end

    // Sticky event bits; writing one clears, but a new event in that cycle wins.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            event_reg <= 3'h0;
        end else begin
            event_reg <= (event_reg & ~(wr_event ? w_data_reg[2:0] : 3'h0))
                | {tin_reg, xmr_reg, xpr_reg};
        end
    end

    // Transmit sequencing, acknowledgement and recovery.
    always_ff @(posedge i_clock) begin
        link_reg <= '0;
        xpr_reg <= 1'b0;
        xmr_reg <= 1'b0;
        tin_reg <= 1'b0;
        timer_start_reg <= 1'b0;
        if (i_rst) begin
            state_reg <= ST_IDLE;
            is_iframe_reg <= 1'b0;
            wfa_reg <= 1'b0;
            timer_recovery_flag_reg <= 1'b0;
            rc_reg <= 4'h0;
        end else if (cmd_transmitter_reset_cmd) begin
            // Transmitter reset drops the frame and hands the pool back.
            link_reg.abort <= state_reg == ST_SEND;
            xpr_reg <= 1'b1;
            state_reg <= ST_IDLE;
            wfa_reg <= 1'b0;
            timer_recovery_flag_reg <= 1'b0;
            rc_reg <= 4'h0;
        end else if (cmd_rhr) begin
            link_reg.rx_reset <= 1'b1;
            timer_recovery_flag_reg <= 1'b0;
            rc_reg <= 4'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (cmd_xif && auto_mode && mode_reg[MODE_TMD_BIT] && !wfa_reg) begin
                        link_reg.start <= 1'b1;
                        is_iframe_reg <= 1'b1;
                        state_reg <= ST_SEND;
                    end else if (cmd_xtf) begin
                        link_reg.start <= 1'b1;
                        link_reg.transparent <= 1'b1;
                        is_iframe_reg <= 1'b0;
                        state_reg <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (i_link.collision && !i_link.pool_released) begin
                        link_reg.retransmit <= 1'b1;
                    end else if (i_link.collision) begin
                        link_reg.abort <= 1'b1;
                        xmr_reg <= 1'b1;
                        timer_recovery_flag_reg <= 1'b0;
                        rc_reg <= 4'h0;
                        state_reg <= ST_IDLE;
                    end else if (i_link.frame_done && is_iframe_reg && auto_mode) begin
                        wfa_reg <= 1'b1;
                        timer_start_reg <= 1'b1;
                        state_reg <= ST_WAIT_ACK;
                    end else if (i_link.frame_done) begin
                        xpr_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_WAIT_ACK: begin
                    if (!auto_mode) begin
                        // Leaving auto mode keeps the waiting flag for software.
                        state_reg <= ST_IDLE;
                    end else if (i_link.pos_ack) begin
                        xpr_reg <= 1'b1;
                        wfa_reg <= 1'b0;
                        timer_recovery_flag_reg <= 1'b0;
                        rc_reg <= 4'h0;
                        state_reg <= ST_IDLE;
                    end else if (i_link.neg_ack) begin
                        xmr_reg <= 1'b1;
                        wfa_reg <= 1'b0;
                        timer_recovery_flag_reg <= 1'b0;
                        rc_reg <= 4'h0;
                        state_reg <= ST_IDLE;
                    end else if (timer_expired && rc_reg < retry_limit_reg) begin
                        link_reg.send_poll <= 1'b1;
                        rc_reg <= rc_reg + 4'h1;
                        timer_recovery_flag_reg <= 1'b1;
                        timer_start_reg <= 1'b1;
                    end else if (timer_expired) begin
                        tin_reg <= 1'b1;
                        xpr_reg <= 1'b1;
                        wfa_reg <= 1'b0;
                        timer_recovery_flag_reg <= 1'b0;
                        rc_reg <= 4'h0;
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // The timer halts on any timer write that strobes byte 0 or 1 and whenever auto mode is off.
    ack_timer_unit #(
        .UNIT_CYCLES(UNIT_CYCLES)
    ) u_ack_timer (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_start(timer_start_reg),
        .i_stop(wr_timer || !auto_mode || cmd_transmitter_reset_cmd),
        .i_period(period_reg),
        .o_expired(timer_expired),
        .o_running(timer_running)
    );

    // Outputs come straight from flip-flops.
    assign o_axi = '{awready: aw_free_reg, wready: w_free_reg, bvalid: bvalid_reg,
        bresp: bresp_reg, arready: ar_free_reg, rvalid: rvalid_reg, rdata: rdata_reg,
        rresp: rresp_reg};
    assign o_link = link_reg;
    assign o_transmit_pool_ready_irq = xpr_reg;
    assign o_message_repeat_irq = xmr_reg;
    assign o_timer_expiry_irq = tin_reg;
    assign o_waiting_for_ack_flag = wfa_reg;
    assign o_timer_recovery_flag = timer_recovery_flag_reg;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    // Checks tying each event to its cause.
    AST_XPR_ON_POS_ACK: assert property (state_reg == ST_WAIT_ACK && auto_mode && !wr_cmd
        && i_link.pos_ack |=> o_transmit_pool_ready_irq && !wfa_reg)
        else $error("pool-ready missing after positive acknowledge");
    AST_XMR_ON_NEG_ACK: assert property (state_reg == ST_WAIT_ACK && auto_mode && !wr_cmd
        && !i_link.pos_ack && i_link.neg_ack |=> o_message_repeat_irq)
        else $error("message-repeat missing after negative acknowledge");
    AST_TIN_WITH_XPR: assert property (o_timer_expiry_irq |-> o_transmit_pool_ready_irq
        && $past(rc_reg) == $past(retry_limit_reg))
        else $error("timer event without pool-ready or before retry limit");
    AST_IFRAME_NEEDS_AUTO: assert property (o_link.start && !o_link.transparent
        |-> $past(auto_mode) && $past(mode_reg[MODE_TMD_BIT]) && $past(!wfa_reg))
        else $error("I frame started outside auto mode with internal timer");
    AST_EARLY_COLLISION: assert property (state_reg == ST_SEND && !wr_cmd
        && i_link.collision && !i_link.pool_released
        |=> o_link.retransmit && !o_message_repeat_irq && state_reg == ST_SEND)
        else $error("early collision not retried by hardware");
    AST_LATE_COLLISION: assert property (state_reg == ST_SEND && !wr_cmd
        && i_link.collision && i_link.pool_released |=> o_link.abort && o_message_repeat_irq)
        else $error("late collision not aborted with message-repeat");
    AST_STATE7_AFTER_XMR: assert property (o_message_repeat_irq |-> !timer_recovery_flag_reg)
        else $error("message-repeat left link in recovery");
    AST_TIMER_STOPS: assert property (wr_timer || !auto_mode |=> !timer_running)
        else $error("timer still running after stop condition");
    AST_RC_CLEARED: assert property ($fell(timer_recovery_flag_reg) |-> rc_reg == 4'h0)
        else $error("retransmission counter kept on leaving recovery");
    AST_POLL_BOUND: assert property (o_link.send_poll |-> rc_reg <= retry_limit_reg
        && rc_reg != 4'h0 && o_timer_recovery_flag)
        else $error("poll frame beyond retry limit");
    AST_ONE_OUTSTANDING: assert property (wfa_reg |-> state_reg != ST_SEND
        || !is_iframe_reg)
        else $error("second I frame while one is unacknowledged");

    COV_IFRAME_ACKED: cover property (o_link.start ##[1:200] o_transmit_pool_ready_irq);
    COV_RECOVERY_POLL: cover property (o_link.send_poll);
    COV_TIMEOUT: cover property (o_timer_expiry_irq);
    COV_LATE_COLLISION: cover property (o_link.abort && o_message_repeat_irq);

endmodule // lapd_xmit_ctrl

/* File: hdl/lapd_xmit_pkg.sv */
package lapd_xmit_pkg;

    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_TIMER = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_EVENT = 8'h10;

    // Register selector codes returned by the address decoder.
    localparam logic [2:0] SEL_MODE = 3'h0;
    localparam logic [2:0] SEL_CMD = 3'h1;
    localparam logic [2:0] SEL_TIMER = 3'h2;
    localparam logic [2:0] SEL_STATUS = 3'h3;
    localparam logic [2:0] SEL_EVENT = 3'h4;
    localparam logic [2:0] SEL_NONE = 3'h7;

    // Field positions.
    localparam int MODE_NAM_BIT = 0;
    localparam int MODE_TMD_BIT = 1;
    localparam int CMD_XIF_BIT = 0;
    localparam int CMD_XTF_BIT = 1;
    localparam int CMD_TRANSMITTER_RESET_CMD_BIT = 2;
    localparam int CMD_RHR_BIT = 3;
    localparam int TMR_PERIOD_LSB = 0;
    localparam int TMR_RETRY_LSB = 8;
    localparam int ST_WFA_BIT = 0;
    localparam int ST_TIMER_RECOVERY_FLAG_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    localparam int ST_TXACT_BIT = 3;
    localparam int ST_RC_LSB = 4;
    localparam int EV_XPR_BIT = 0;
    localparam int EV_XMR_BIT = 1;
    localparam int EV_TIN_BIT = 2;

    // Reset values: non-auto operation, external timer mode.
    localparam logic [1:0] MODE_RESET = 2'h1;
    localparam logic [7:0] PERIOD_RESET = 8'h0a;
    localparam logic [3:0] RETRY_RESET = 4'h3;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One timer unit lasts ACK_UNIT_US microseconds.
    localparam int CLOCK_MHZ = 250;
    localparam int ACK_UNIT_US = 1;
    localparam int ACK_UNIT_CYCLES = ACK_UNIT_US * CLOCK_MHZ;

    typedef enum {ST_IDLE, ST_SEND, ST_WAIT_ACK} xmit_state_e;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_s;

    typedef struct packed {
        logic pos_ack;
        logic neg_ack;
        logic collision;
        logic pool_released;
        logic frame_done;
        logic peer_busy;
    } link_in_s;

    typedef struct packed {
        logic start;
        logic transparent;
        logic retransmit;
        logic abort;
        logic send_poll;
        logic rx_reset;
    } link_out_s;

endpackage

/* File: verification/lapd_link_peer.sv */
`timescale 1ns/1ps
// Far end of the link: finishes each frame after a short delay and answers as commanded.
module lapd_link_peer
    import lapd_xmit_pkg::*;
(
    input wire logic i_clock,
    input wire link_out_s i_link,
    input wire logic [1:0] i_ack_kind,
    input wire logic [1:0] i_coll_kind,
    output link_in_s o_link
);
    logic [1:0] hit;
    logic tr;
    // Pulses last one cycle and the pool level drops outside frames, so nothing stale lingers.
    initial begin
        o_link = '0;
        tr = 1'b0;
        hit = 2'h0;
        forever begin
            @(posedge i_clock);
            o_link <= '0;
            if (i_link.start || i_link.retransmit) begin
                if (i_link.start) begin
                    tr = i_link.transparent;
                    hit = i_coll_kind;
                end
                repeat (3) @(posedge i_clock);
                if (hit != 2'h0) begin
                    o_link.collision <= 1'b1;
                    o_link.pool_released <= hit[1];
                    hit = 2'h0;
                end else begin
                    o_link.frame_done <= 1'b1;
                    if (!tr && i_ack_kind != 2'h2) begin
                        @(posedge i_clock);
                        o_link.frame_done <= 1'b0;
                        repeat (3) @(posedge i_clock);
                        o_link.pos_ack <= (i_ack_kind == 2'h0);
                        o_link.neg_ack <= (i_ack_kind == 2'h1);
                    end
                end
            end
        end
    end
endmodule // lapd_link_peer

/* File: verification/lapd_xmit_ctrl_tb.sv */
`timescale 1ns/1ps
// Expected events and read data wait in queues until the monitor sees the design answer.
module lapd_xmit_ctrl_tb;
    import lapd_xmit_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    axi_req_s ax = '0;
    axi_rsp_s o_axi;
    link_in_s lin;
    link_out_s lout;
    logic transmit_pool_ready_irq, message_repeat_irq, timer_expiry_irq, waiting_for_ack_flag, timer_recovery_flag;
    logic [1:0] ack_kind = 2'h0;
    logic [1:0] coll_kind = 2'h0;
    logic [2:0] ev_q[$];
    logic [33:0] rd_q[$];
    int n_errors = 0;
    int n_compared = 0;
    int n_poll = 0;
    int cycles = 0;
    logic [7:0] per;

    always #2 i_clock = ~i_clock;

    lapd_xmit_ctrl #(.UNIT_CYCLES(2)) dut (.i_clock(i_clock), .i_rst(i_rst), .i_axi(ax),
        .o_axi(o_axi), .i_link(lin), .o_link(lout), .o_transmit_pool_ready_irq(transmit_pool_ready_irq),
        .o_message_repeat_irq(message_repeat_irq), .o_timer_expiry_irq(timer_expiry_irq), .o_waiting_for_ack_flag(waiting_for_ack_flag),
        .o_timer_recovery_flag(timer_recovery_flag));
    lapd_link_peer peer (.i_clock(i_clock), .i_link(lout), .i_ack_kind(ack_kind),
        .i_coll_kind(coll_kind), .o_link(lin));

    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Events are one-cycle pulses, so every edge that shows one is a result of its own.
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            close_out();
        end
        if (!i_rst && {timer_expiry_irq, message_repeat_irq, transmit_pool_ready_irq} !== 3'h0) begin
            check("event", {31'h0, timer_expiry_irq, message_repeat_irq, transmit_pool_ready_irq}, {31'h0, ev_q.pop_front()});
        end
        if (o_axi.rvalid && ax.rready) check("read", {o_axi.rresp, o_axi.rdata}, rd_q.pop_front());
        if (lout.send_poll === 1'b1) n_poll++;
    end

    // Each bus task starts on a fresh edge, so a strobe is never assigned twice in one step.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        @(posedge i_clock);
        ax.awaddr <= a;
        ax.wdata <= d;
        ax.wstrb <= 4'hf;
        ax.awvalid <= 1'b1;
        ax.wvalid <= 1'b1;
        ax.bready <= 1'b1;
        do begin
            @(posedge i_clock);
            if (ax.awvalid && o_axi.awready) ax.awvalid <= 1'b0;
            if (ax.wvalid && o_axi.wready) ax.wvalid <= 1'b0;
        end while (o_axi.bvalid !== 1'b1);
        ax.bready <= 1'b0;
        check("bresp", {32'h0, o_axi.bresp}, {32'h0, resp});
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] exp);
        @(posedge i_clock);
        rd_q.push_back(exp);
        ax.araddr <= a;
        ax.arvalid <= 1'b1;
        ax.rready <= 1'b1;
        do begin
            @(posedge i_clock);
            if (ax.arvalid && o_axi.arready) ax.arvalid <= 1'b0;
        end while (o_axi.rvalid !== 1'b1);
        ax.rready <= 1'b0;
    endtask

    task automatic frame(input string name, input logic [31:0] cmd, input logic [2:0] exp);
        if (exp != 3'h0) ev_q.push_back(exp);
        wr(OFS_CMD, cmd, RESP_OKAY);
        for (int i = 0; i < 80 && ev_q.size() != 0; i++) @(posedge i_clock);
        repeat (10) @(posedge i_clock);
        check("events left", 34'(ev_q.size()), 34'h0);
        $display("done %s", name);
    endtask

    // Main sequence; the random timer period reaches the design through the register bus.
    initial begin
        void'($urandom(93326));
        per = 8'($urandom_range(3, 1));
        repeat (3) @(posedge i_clock);
        i_rst <= 1'b0;
        rd(OFS_MODE, {RESP_OKAY, 32'(MODE_RESET)});
        rd(OFS_TIMER, {RESP_OKAY, 20'h0, RETRY_RESET, PERIOD_RESET});
        rd(8'h14, {RESP_SLVERR, 32'h0});
        wr(8'h14, 32'h1, RESP_SLVERR);
        $display("done registers");
        frame("refused i frame", 32'h1, 3'h0);
        frame("transparent", 32'h2, 3'h1);
        coll_kind <= 2'h1;
        frame("early collision", 32'h2, 3'h1);
        coll_kind <= 2'h2;
        frame("late collision", 32'h2, 3'h2);
        coll_kind <= 2'h0;
        wr(OFS_MODE, 32'h2, RESP_OKAY);
        frame("acked i frame", 32'h1, 3'h1);
        check("waiting flag", {33'h0, waiting_for_ack_flag}, 34'h0);
        ack_kind <= 2'h1;
        frame("rejected i frame", 32'h1, 3'h2);
        check("recovery flag", {33'h0, timer_recovery_flag}, 34'h0);
        coll_kind <= 2'h2;
        frame("auto late collision", 32'h1, 3'h2);
        coll_kind <= 2'h0;
        ack_kind <= 2'h2;
        wr(OFS_TIMER, {20'h0, 4'h1, per}, RESP_OKAY);
        rd(OFS_TIMER, {RESP_OKAY, 20'h0, 4'h1, per});
        frame("unanswered i frame", 32'h1, 3'h5);
        check("poll count", 34'(n_poll), 34'h1);
        check("recovery flag", {33'h0, timer_recovery_flag}, 34'h0);
        // Every event kind has fired by now, so all sticky bits must read set.
        rd(OFS_EVENT, {RESP_OKAY, 32'h7});
        wr(OFS_EVENT, 32'h7, RESP_OKAY);
        rd(OFS_EVENT, {RESP_OKAY, 32'h0});
        wr(OFS_MODE, 32'h1, RESP_OKAY);
        rd(OFS_STATUS, {RESP_OKAY, 32'h0});
        wr(OFS_TIMER, 32'h30a, RESP_OKAY);
        frame("transparent after auto", 32'h2, 3'h1);
        // Both resets are issued only once the last frame has ended.
        frame("transmitter reset", 32'h4, 3'h1);
        frame("receiver reset", 32'h8, 3'h0);
        close_out();
    end
endmodule // lapd_xmit_ctrl_tb
